// [lse_exec.v]
// execute unit for test, wait, swap, table lookup and exclusive-or
`include "lse_map.vh"
module lse_exec (
  input wire CLK_SYS,
  input wire RESETN,
  input wire START,
  input wire [7:0] OPCODE,
  input wire [7:0] MODRM,
  input wire [15:0] IMM,
  input wire LOCK_PREFIX,
  input wire TEST_RELEASE_N,
  input wire [15:0] EA_ADDR,
  input wire [15:0] REG_RDATA,
  input wire [15:0] REG_RDATA_B,
  input wire [15:0] ACC_WORD,
  input wire [15:0] TABLE_BASE,
  input wire MEM_DONE,
  input wire [15:0] MEM_RDATA,
  output wire BUSY,
  output reg DONE,
  output reg ILLEGAL,
  output reg [2:0] REG_RADDR,
  output reg [2:0] REG_RADDR_B,
  output reg REG_WE,
  output reg [2:0] REG_WADDR,
  output reg REG_WWIDE,
  output reg [15:0] REG_WDATA,
  output reg REG_WE_B,
  output reg [2:0] REG_WADDR_B,
  output reg [15:0] REG_WDATA_B,
  output reg MEM_REQ,
  output reg MEM_WR,
  output reg MEM_WIDE,
  output reg [15:0] MEM_ADDR,
  output reg [15:0] MEM_WDATA,
  output reg BUS_LOCK,
  output reg FLAGS_WE,
  output reg CARRY_FLAG,
  output reg OVERFLOW_FLAG,
  output reg PARITY_FLAG,
  output reg SIGN_FLAG,
  output reg ZERO_FLAG
);
  localparam S_IDLE = 3'h0;
  localparam S_RD = 3'h1;
  localparam S_WR = 3'h2;
  localparam S_WAIT = 3'h3;
  localparam S_CNT = 3'h4;
  localparam S_FIN = 3'h5;
  localparam S_PAD = 3'h6;

  localparam K_TEST = 2'h0;
  localparam K_XOR = 2'h1;
  localparam K_SWAP = 2'h2;
  localparam K_LOOK = 2'h3;

  reg [2:0] st_q;
  reg [1:0] kind_q;
  reg wide_q;
  reg to_reg_q;
  reg mem_q;
  reg use_imm_q;
  reg [15:0] imm_q;
  reg [2:0] reg_q;
  reg [2:0] rm_q;
  reg [7:0] cnt_q;
  reg [15:0] res_q;
  reg [15:0] tmp_q;
  reg rel_s1_q;
  reg rel_s2_q;

  // even parity over the low byte only, as the flag is defined
  function parity_of;
    input [7:0] v;
    begin
      parity_of = ~^v;
    end
  endfunction

  // AND and XOR share one flag update; width picks the sign bit
  task set_logic_flags;
    input [15:0] r;
    input w;
    begin
      FLAGS_WE <= 1'b1;
      CARRY_FLAG <= 1'b0;
      OVERFLOW_FLAG <= 1'b0;
      PARITY_FLAG <= parity_of(r[7:0]);
      SIGN_FLAG <= w ? r[15] : r[7];
      ZERO_FLAG <= w ? (r == 16'h0000) : (r[7:0] == 8'h00);
    end
  endtask

  assign BUSY = (st_q != S_IDLE);

  wire is_test_rm = (OPCODE[7:1] == `LSE_OP_TEST_RM);
  wire is_test_imm = (OPCODE[7:1] == `LSE_OP_TEST_IMM) && (MODRM[5:3] == `LSE_REG_TEST);
  wire is_test_acc = (OPCODE[7:1] == `LSE_OP_TEST_ACC);
  wire is_swap_rm = (OPCODE[7:1] == `LSE_OP_SWAP_RM);
  // swapping the accumulator with itself changes nothing, so it ends at once
  wire is_swap_acc = (OPCODE[7:3] == `LSE_OP_SWAP_ACC) && (OPCODE != `LSE_OP_NOP);
  wire is_nop = (OPCODE == `LSE_OP_NOP);
  wire is_look = (OPCODE == `LSE_OP_LOOKUP);
  wire is_wait = (OPCODE == `LSE_OP_WAIT);
  wire is_xor_rm = (OPCODE[7:2] == `LSE_OP_XOR_RM);
  wire is_xor_imm = (OPCODE[7:2] == `LSE_OP_XOR_IMM) && (MODRM[5:3] == `LSE_REG_XOR);
  wire is_xor_acc = (OPCODE[7:1] == `LSE_OP_XOR_ACC);
  wire modrm_mem = (MODRM[7:6] != `LSE_MOD_REG);
  wire w_bit = OPCODE[0];

  always @* begin
    REG_RADDR = START ? MODRM[5:3] : reg_q;
    REG_RADDR_B = START ? MODRM[2:0] : rm_q;
    if (START && is_swap_acc) begin
      REG_RADDR_B = OPCODE[2:0];
    end
  end

  function [15:0] opsel;
    input [15:0] v;
    input w;
    begin
      opsel = w ? v : {8'h00, v[7:0]};
    end
  endfunction

  always @(posedge CLK_SYS) begin
    rel_s1_q <= ~TEST_RELEASE_N;
    rel_s2_q <= rel_s1_q;
    if (!RESETN) begin
      st_q <= S_IDLE;
      kind_q <= K_TEST;
      wide_q <= 1'b0;
      to_reg_q <= 1'b0;
      mem_q <= 1'b0;
      use_imm_q <= 1'b0;
      imm_q <= 16'h0000;
      reg_q <= 3'h0;
      rm_q <= 3'h0;
      cnt_q <= 8'h00;
      res_q <= 16'h0000;
      tmp_q <= 16'h0000;
      DONE <= 1'b0;
      ILLEGAL <= 1'b0;
      REG_WE <= 1'b0;
      REG_WADDR <= 3'h0;
      REG_WWIDE <= 1'b0;
      REG_WDATA <= 16'h0000;
      REG_WE_B <= 1'b0;
      REG_WADDR_B <= 3'h0;
      REG_WDATA_B <= 16'h0000;
      MEM_REQ <= 1'b0;
      MEM_WR <= 1'b0;
      MEM_WIDE <= 1'b0;
      MEM_ADDR <= 16'h0000;
      MEM_WDATA <= 16'h0000;
      BUS_LOCK <= 1'b0;
      FLAGS_WE <= 1'b0;
      CARRY_FLAG <= 1'b0;
      OVERFLOW_FLAG <= 1'b0;
      PARITY_FLAG <= 1'b0;
      SIGN_FLAG <= 1'b0;
      ZERO_FLAG <= 1'b0;
      rel_s1_q <= 1'b0;
      rel_s2_q <= 1'b0;
    end else begin
      DONE <= 1'b0;
      ILLEGAL <= 1'b0;
      REG_WE <= 1'b0;
      REG_WE_B <= 1'b0;
      FLAGS_WE <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (START) begin
            wide_q <= w_bit;
            imm_q <= IMM;
            reg_q <= MODRM[5:3];
            rm_q <= MODRM[2:0];
            mem_q <= modrm_mem;
            use_imm_q <= 1'b0;
            to_reg_q <= 1'b0;
            cnt_q <= 8'h00;
            if (is_test_rm || is_test_imm || is_xor_rm || is_xor_imm || is_swap_rm) begin
              kind_q <= (is_test_rm || is_test_imm) ? K_TEST : (is_swap_rm ? K_SWAP : K_XOR);
              use_imm_q <= is_test_imm || is_xor_imm;
              to_reg_q <= is_xor_rm && OPCODE[1];
              tmp_q <= opsel((is_test_imm || is_xor_imm) ? IMM : REG_RDATA, w_bit);
              res_q <= opsel(REG_RDATA_B, w_bit);
              if (modrm_mem) begin
                MEM_REQ <= 1'b1;
                MEM_WR <= 1'b0;
                MEM_WIDE <= w_bit;
                MEM_ADDR <= EA_ADDR;
                BUS_LOCK <= is_swap_rm && LOCK_PREFIX;
                st_q <= S_RD;
              end else begin
                st_q <= S_FIN;
              end
            end else if (is_test_acc || is_xor_acc) begin
              kind_q <= is_test_acc ? K_TEST : K_XOR;
              to_reg_q <= 1'b1;
              reg_q <= `LSE_ACC_IDX;
              use_imm_q <= 1'b1;
              tmp_q <= opsel(IMM, w_bit);
              res_q <= opsel(ACC_WORD, w_bit);
              st_q <= S_FIN;
            end else if (is_swap_acc) begin
              REG_WE <= 1'b1;
              REG_WWIDE <= 1'b1;
              REG_WADDR <= `LSE_ACC_IDX;
              REG_WDATA <= REG_RDATA_B;
              REG_WE_B <= 1'b1;
              REG_WADDR_B <= OPCODE[2:0];
              REG_WDATA_B <= ACC_WORD;
              DONE <= 1'b1;
            end else if (is_nop) begin
              DONE <= 1'b1;
            end else if (is_look) begin
              kind_q <= K_LOOK;
              MEM_REQ <= 1'b1;
              MEM_WR <= 1'b0;
              MEM_WIDE <= 1'b0;
              MEM_ADDR <= TABLE_BASE + {8'h00, ACC_WORD[7:0]};
              cnt_q <= 8'h01;
              st_q <= S_RD;
            end else if (is_wait) begin
              cnt_q <= `LSE_WAIT_BASE - 8'h01;
              st_q <= S_CNT;
            end else begin
              ILLEGAL <= 1'b1;
              DONE <= 1'b1;
            end
          end
        end
        S_RD: begin
          if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q + 8'h01;
          end
          if (MEM_DONE) begin
            MEM_REQ <= 1'b0;
            if (kind_q == K_LOOK) begin
              REG_WADDR <= `LSE_ACC_IDX;
              REG_WWIDE <= 1'b0;
              REG_WDATA <= {ACC_WORD[15:8], MEM_RDATA[7:0]};
              st_q <= S_PAD;
            end else begin
              res_q <= opsel(MEM_RDATA, wide_q);
              st_q <= S_FIN;
            end
          end
        end
        S_PAD: begin
          // own state, so a later wait never inherits the lookup's kind
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q >= `LSE_LOOKUP_CLKS - 8'h01) begin
            REG_WE <= 1'b1;
            DONE <= 1'b1;
            cnt_q <= 8'h00;
            st_q <= S_IDLE;
          end
        end
        S_CNT: begin
          // release is looked at only once per polling step
          if (cnt_q > 8'h01) begin
            cnt_q <= cnt_q - 8'h01;
          end else if (rel_s2_q) begin
            DONE <= 1'b1;
            st_q <= S_IDLE;
          end else begin
            cnt_q <= `LSE_WAIT_POLL;
            st_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h02) begin
            st_q <= S_CNT;
          end
        end
        S_FIN: begin
          if (kind_q == K_TEST) begin
            set_logic_flags(res_q & tmp_q, wide_q);
            DONE <= 1'b1;
            st_q <= S_IDLE;
          end else if (kind_q == K_XOR) begin
            set_logic_flags(res_q ^ tmp_q, wide_q);
            if (to_reg_q || !mem_q) begin
              REG_WE <= 1'b1;
              REG_WWIDE <= wide_q;
              REG_WADDR <= to_reg_q ? reg_q : rm_q;
              REG_WDATA <= res_q ^ tmp_q;
              DONE <= 1'b1;
              st_q <= S_IDLE;
            end else begin
              MEM_REQ <= 1'b1;
              MEM_WR <= 1'b1;
              MEM_WDATA <= res_q ^ tmp_q;
              st_q <= S_WR;
            end
          end else begin
            REG_WE <= 1'b1;
            REG_WWIDE <= wide_q;
            REG_WADDR <= reg_q;
            REG_WDATA <= res_q;
            if (mem_q) begin
              MEM_REQ <= 1'b1;
              MEM_WR <= 1'b1;
              MEM_WDATA <= tmp_q;
              st_q <= S_WR;
            end else begin
              REG_WE_B <= 1'b1;
              REG_WADDR_B <= rm_q;
              REG_WDATA_B <= tmp_q;
              DONE <= 1'b1;
              st_q <= S_IDLE;
            end
          end
        end
        S_WR: begin
          if (MEM_DONE) begin
            MEM_REQ <= 1'b0;
            MEM_WR <= 1'b0;
            BUS_LOCK <= 1'b0;
            DONE <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule // lse_exec

// [lse_exec_sva.sv]
// checker for the logic, swap, lookup and exclusive-or execute block
module lse_exec_sva (
  input wire CLK_SYS,
  input wire RESETN,
  input wire START,
  input wire BUSY,
  input wire DONE,
  input wire REG_WE,
  input wire MEM_REQ,
  input wire MEM_DONE,
  input wire MEM_WR,
  input wire BUS_LOCK,
  input wire FLAGS_WE,
  input wire CARRY_FLAG,
  input wire OVERFLOW_FLAG,
  input wire [7:0] OPCODE,
  input wire [7:0] MODRM,
  input wire [15:0] MEM_ADDR
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  wire take = START && !BUSY;
  logic_flags_a: assert property (FLAGS_WE |-> !CARRY_FLAG && !OVERFLOW_FLAG)
    else $error("carry or overflow set by logic op");
  test_reg_a: assert property (take && OPCODE[7:1] == 7'h42 && MODRM[7:6] == 2'h3 |=> !REG_WE ##1 DONE && !REG_WE)
    else $error("register test wrote a result or ran late");
  swap_acc_a: assert property (take && OPCODE[7:3] == 5'h12 && OPCODE[2:0] != 3'h0 |=> DONE && !FLAGS_WE)
    else $error("accumulator swap timing or flags wrong");
  lookup_time_a: assert property (take && OPCODE == 8'hd7 |=> !DONE [*8] ##3 DONE)
    else $error("lookup not done in eleven clocks");
  mem_hold_a: assert property (MEM_REQ && !MEM_DONE |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WR))
    else $error("memory request dropped before completion");
  wait_flags_a: assert property (take && OPCODE == 8'h9b |=> (!FLAGS_WE && !DONE) [*2])
    else $error("wait touched flags or ended early");
  lock_req_a: assert property ($rose(BUS_LOCK) |-> MEM_REQ && !MEM_WR)
    else $error("bus lock not raised with the read");
  lock_hold_a: assert property (BUS_LOCK && !(MEM_DONE && MEM_WR) |=> BUS_LOCK)
    else $error("bus lock released before the write");
endmodule // lse_exec_sva
bind lse_exec lse_exec_sva sva_u (.*);

// [lse_map.vh]
// constants for the logic, swap, lookup and exclusive-or execute block
`ifndef LSE_MAP_VH
`define LSE_MAP_VH
`define LSE_OP_TEST_RM 7'h42
`define LSE_OP_TEST_IMM 7'h7b
`define LSE_OP_TEST_ACC 7'h54
`define LSE_OP_SWAP_RM 7'h43
`define LSE_OP_SWAP_ACC 5'h12
`define LSE_OP_LOOKUP 8'hd7
`define LSE_OP_WAIT 8'h9b
`define LSE_OP_NOP 8'h90
`define LSE_OP_XOR_RM 6'h0c
`define LSE_OP_XOR_IMM 6'h20
`define LSE_OP_XOR_ACC 7'h1a
`define LSE_REG_TEST 3'h0
`define LSE_REG_XOR 3'h6
`define LSE_MOD_REG 2'h3
`define LSE_WAIT_BASE 8'h03
`define LSE_WAIT_POLL 8'h05
`define LSE_LOOKUP_CLKS 8'h0b
`define LSE_ACC_IDX 3'h0
`endif

// [lse_mem_model.sv]
// byte-wide operand memory answering the block's transfer requests
module lse_mem_model (
  input wire clk,
  input wire req,
  input wire wr,
  input wire wide,
  input wire [15:0] addr,
  input wire [15:0] wdata,
  input wire slow,
  output logic done = 1'b0,
  output logic [15:0] rdata = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] m [0:65535];
  logic [1:0] cnt = 2'h0;
  // no other master here, so a locked pair is trivially indivisible
  always @(posedge clk) begin
    done <= 1'b0;
    rdata <= ~rdata;
    if (req && !done) begin
      if (cnt == (slow ? 2'h2 : 2'h0)) begin
        cnt <= 2'h0;
        done <= 1'b1;
        if (wr) begin
          m[addr] <= wdata[7:0];
          if (wide) m[addr + 16'h1] <= wdata[15:8];
        end else begin
          rdata <= {wide ? m[addr + 16'h1] : 8'h00, m[addr]};
        end
      end else begin
        cnt <= cnt + 2'h1;
      end
    end else begin
      cnt <= 2'h0;
    end
  end
endmodule // lse_mem_model

// [tb_logic_swap_lookup_exec.sv]
// testbench for the logic, swap, lookup and exclusive-or execute block
module tb_logic_swap_lookup_exec;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_SYS = 0, RESETN = 0, START = 0, LOCK_PREFIX = 0, TEST_RELEASE_N = 0, slow = 0;
  logic [7:0] OPCODE = 0, MODRM = 0;
  logic [15:0] IMM = 0, EA_ADDR = 0, TABLE_BASE = 0, wd, wdb;
  logic [15:0] rf [0:7];
  logic [2:0] wa;
  logic zf, sf, pf, ill, ww;
  wire [15:0] REG_RDATA, REG_RDATA_B, ACC_WORD, MEM_RDATA, REG_WDATA, REG_WDATA_B, MEM_ADDR, MEM_WDATA;
  wire MEM_DONE, BUSY, DONE, ILLEGAL, REG_WE, REG_WWIDE, REG_WE_B, MEM_REQ, MEM_WR, MEM_WIDE, BUS_LOCK;
  wire FLAGS_WE, CARRY_FLAG, OVERFLOW_FLAG, PARITY_FLAG, SIGN_FLAG, ZERO_FLAG;
  wire [2:0] REG_RADDR, REG_RADDR_B, REG_WADDR, REG_WADDR_B;
  int miscompares = 0, n_tests = 0, cyc;
  assign REG_RDATA = rf[REG_RADDR];
  assign REG_RDATA_B = rf[REG_RADDR_B];
  assign ACC_WORD = rf[0];
  lse_exec dut_u (.*);
  lse_mem_model mem_u (.clk(CLK_SYS), .req(MEM_REQ), .wr(MEM_WR), .wide(MEM_WIDE), .addr(MEM_ADDR),
    .wdata(MEM_WDATA), .slow(slow), .done(MEM_DONE), .rdata(MEM_RDATA));
  always #25 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) begin
    if (REG_WE) begin
      wd <= REG_WDATA;
      wa <= REG_WADDR;
      ww <= REG_WWIDE;
    end
    if (REG_WE_B) wdb <= REG_WDATA_B;
    if (FLAGS_WE) begin
      zf <= ZERO_FLAG;
      sf <= SIGN_FLAG;
      pf <= PARITY_FLAG;
    end
  end
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task run(input logic [7:0] op, input logic [7:0] mo, input logic [15:0] im, input logic [15:0] ea);
    @(negedge CLK_SYS);
    OPCODE = op;
    MODRM = mo;
    IMM = im;
    EA_ADDR = ea;
    START = 1;
    @(negedge CLK_SYS);
    START = 0;
    cyc = 1;
    while (DONE !== 1'b1 && cyc < 200) begin
      @(negedge CLK_SYS);
      cyc++;
    end
    ill = ILLEGAL;
    chk(DONE, 1'b1);
    // write and flag captures land on the edge after done
    @(negedge CLK_SYS);
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    rf = '{16'h1234, 16'h0f0f, 16'h00ff, 16'h1111, 16'h0, 16'h0, 16'h0, 16'h0};
    mem_u.m[16'h0100] = 8'h00;
    mem_u.m[16'h0101] = 8'h80;
    mem_u.m[16'h0200] = 8'h5a;
    mem_u.m[16'h02ff] = 8'h3c;
    mem_u.m[16'h0300] = 8'hef;
    mem_u.m[16'h0301] = 8'hbe;
    mem_u.m[16'h0400] = 8'hff;
    repeat (5) @(negedge CLK_SYS);
    RESETN = 1;
    run(8'h33, 8'hca, 16'h0, 16'h0);
    chk(wd, 16'h0ff0);
    chk(wa, 3'h1);
    chk(pf, 1'b1);
    run(8'h85, 8'hca, 16'h0, 16'h0);
    chk(zf, 1'b0);
    chk(wd, 16'h0ff0);
    run(8'hf7, 8'h06, 16'h8000, 16'h0100);
    chk(sf, 1'b1);
    // high immediate byte would clear the zero flag if misused
    run(8'ha8, 8'h00, 16'hffcb, 16'h0);
    chk(zf, 1'b1);
    run(8'h35, 8'h00, 16'h1234, 16'h0);
    chk(wd, 16'h0);
    chk(zf, 1'b1);
    run(8'h81, 8'hf1, 16'hffff, 16'h0);
    chk(wd, 16'hf0f0);
    chk(sf, 1'b1);
    run(8'h30, 8'h16, 16'h0, 16'h0400);
    chk(mem_u.m[16'h0400], 8'h00);
    TABLE_BASE = 16'h0200;
    rf[0] = 16'h1200;
    run(8'hd7, 8'h00, 16'h0, 16'h0);
    chk(wd[7:0], 8'h5a);
    chk(cyc, 11);
    rf[0] = 16'h12ff;
    run(8'hd7, 8'h00, 16'h0, 16'h0);
    chk(wd, 16'h123c);
    chk(ww, 1'b0);
    rf[0] = 16'h1234;
    LOCK_PREFIX = 1;
    slow = 1;
    run(8'h87, 8'h1e, 16'h0, 16'h0300);
    chk(wd, 16'hbeef);
    chk({mem_u.m[16'h0301], mem_u.m[16'h0300]}, 16'h1111);
    LOCK_PREFIX = 0;
    slow = 0;
    run(8'h93, 8'h00, 16'h0, 16'h0);
    chk(wd ^ wdb, 16'h0325);
    run(8'h31, 8'hca, 16'h0, 16'h0);
    chk(wa, 3'h2);
    chk(wd, 16'h0ff0);
    run(8'h87, 8'hd1, 16'h0, 16'h0);
    chk(wd, 16'h0f0f);
    chk(wdb, 16'h00ff);
    chk(wa, 3'h2);
    run(8'h90, 8'h00, 16'h0, 16'h0);
    chk(ill, 1'b0);
    chk(cyc, 1);
    run(8'h80, 8'hc1, 16'h0, 16'h0);
    chk(ill, 1'b1);
    // reset in the middle of a wait must abandon it
    TEST_RELEASE_N = 1;
    @(negedge CLK_SYS);
    OPCODE = 8'h9b;
    START = 1;
    @(negedge CLK_SYS);
    START = 0;
    repeat (3) @(negedge CLK_SYS);
    chk(BUSY, 1'b1);
    RESETN = 0;
    @(negedge CLK_SYS);
    RESETN = 1;
    chk({BUSY, DONE, MEM_REQ, BUS_LOCK}, 4'h0);
    TEST_RELEASE_N = 1;
    fork
      run(8'h9b, 8'h00, 16'h0, 16'h0);
      begin
        repeat (9) @(negedge CLK_SYS);
        TEST_RELEASE_N = 0;
      end
    join
    chk((cyc - 3) % 5, 0);
    chk(cyc > 3, 1);
    give_verdict;
  end
  initial begin
    repeat (3000) @(posedge CLK_SYS);
    miscompares++;
    give_verdict;
  end
endmodule // tb_logic_swap_lookup_exec
